/* File: design/pcot_pkg.sv */
package pcot_pkg;
	// Routing path selection for the comparator event
	typedef enum logic [1:0] {
		PCOT_ROUTE_RELAY = 2'h0,
		PCOT_ROUTE_PINS = 2'h1,
		PCOT_ROUTE_BRIGHT = 2'h2,
		PCOT_ROUTE_DIRECT = 2'h3
	} pcot_route_type;

	typedef enum logic [0:0] {
		PCOT_ST_ON = 1'h0,
		PCOT_ST_OFF = 1'h1
	} pcot_state_type;

	localparam int PCOT_OFF_W = 16;
	localparam int PCOT_REF_W = 16;
	localparam logic [PCOT_OFF_W-1:0] PCOT_OFF_RESET = 16'h0064;
	localparam logic [PCOT_REF_W-1:0] PCOT_REF_RESET = 16'h0100;
	localparam logic [PCOT_REF_W-1:0] PCOT_ACC_RESET = 16'h0000;
endpackage

/* File: design/pcot_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R01 - Timer slice output drives the switch gate; high turns the switch on.
// R02 - Comparator input is sampled continuously and reported on its output.
// R03 - Comparator output changes state when current reaches the reference.
// R04 - Peak trigger forces gate low for fixed off time, then high again.
// R05 - Off time is an external stop that also clears the timer count.
// R06 - Off period length is a programmable input setting.
// R07 - Toggling reference output; rate set by software, filtered externally.
// R08 - Comparator event reaches the stop input over one of four paths.
// R09 - Path one forwards the comparator output through an event relay stage.
// R10 - Path two drives the comparator onto a pin; board shorts it to input pin.
// R11 - Path three relays the comparator output through a brightness channel.
// R12 - Path four connects the comparator output straight to the stop input.
// R13 - Events during the off period neither extend nor restart it.
module pcot_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Analog comparator result pin (current above reference)
	input wire logic comp_raw_i,
	// Stop input pin, shorted on the board to the comparator pin
	input wire logic stop_pin_i,
	// Configuration
	input wire logic enable_i,
	input wire pcot_pkg::pcot_route_type route_i,
	input wire logic [pcot_pkg::PCOT_OFF_W-1:0] off_len_i,
	input wire logic [pcot_pkg::PCOT_REF_W-1:0] ref_level_i,
	// Outputs
	output logic gate_o,
	output logic current_comparator_o,
	output logic comp_pin_o,
	output logic ref_toggle_o,
	output logic off_active_o
);

	typedef struct packed {
		logic [1:0] comp_sync;
		logic [1:0] pin_sync;
		logic comp;
		logic comp_prev;
		logic relay;
		logic bright;
		logic stop_prev;
		pcot_pkg::pcot_state_type state;
		logic [pcot_pkg::PCOT_OFF_W-1:0] count;
		logic [pcot_pkg::PCOT_REF_W:0] acc;
		logic gate;
		logic comp_pin;
		logic ref_out;
	} pcot_state_struct_type;

	pcot_state_struct_type r;
	pcot_state_struct_type next_r;
	logic stop_level;
	logic stop_event;

	always_comb begin
		next_r = r;
		// Two-stage synchronisers
		next_r.comp_sync = {r.comp_sync[0], comp_raw_i};
		next_r.pin_sync = {r.pin_sync[0], stop_pin_i};
		next_r.comp = r.comp_sync[1]; // [R02] [R03]
		next_r.comp_prev = r.comp;
		next_r.relay = r.comp; // [R09]
		next_r.bright = r.comp; // [R11]
		next_r.comp_pin = r.comp; // [R10]
		// Route select
		stop_level = r.comp; // [R12]
		if (route_i == pcot_pkg::PCOT_ROUTE_RELAY) begin // [R08]
			stop_level = r.relay;
		end else if (route_i == pcot_pkg::PCOT_ROUTE_PINS) begin
			stop_level = r.pin_sync[1]; // [R10]
		end else if (route_i == pcot_pkg::PCOT_ROUTE_BRIGHT) begin
			stop_level = r.bright;
		end
		next_r.stop_prev = stop_level;
		stop_event = stop_level && !r.stop_prev;
		// Reference generator: first-order delta-sigma toggling output
		next_r.acc = {1'b0, r.acc[pcot_pkg::PCOT_REF_W-1:0]}
			+ {1'b0, ref_level_i}; // [R07]
		next_r.ref_out = r.acc[pcot_pkg::PCOT_REF_W]; // [R07]
		// Switching timer slice
		case (r.state)
			pcot_pkg::PCOT_ST_ON: begin
				next_r.gate = enable_i; // [R01]
				if (enable_i && stop_event) begin
					next_r.state = pcot_pkg::PCOT_ST_OFF; // [R04]
					next_r.count = '0; // [R05]
					next_r.gate = 1'b0; // [R04]
				end
			end
			pcot_pkg::PCOT_ST_OFF: begin
				next_r.gate = 1'b0;
				// Further events ignored while off
				if (r.count + 16'h0001 >= off_len_i) begin // [R06] [R13]
					next_r.state = pcot_pkg::PCOT_ST_ON; // [R04]
					next_r.gate = enable_i;
					next_r.count = '0;
				end else begin
					next_r.count = r.count + 16'h0001;
				end
			end
			default: begin
				next_r.state = pcot_pkg::PCOT_ST_ON;
			end
		endcase
		if (!enable_i) begin
			next_r.state = pcot_pkg::PCOT_ST_ON;
			next_r.count = '0;
			next_r.gate = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign gate_o = r.gate;
	assign current_comparator_o = r.comp;
	assign comp_pin_o = r.comp_pin;
	assign ref_toggle_o = r.ref_out;
	assign off_active_o = (r.state == pcot_pkg::PCOT_ST_OFF);

endmodule // pcot_top

/* File: dv/pcot_monitor.sv */
`timescale 1ns/1ps
module pcot_monitor (
	input wire logic clk_i, rst_i, enable_i, gate_o, current_comparator_o, off_active_o,
	input wire pcot_pkg::pcot_route_type route_i,
	input wire logic [15:0] off_len_i
);
	logic [15:0] n;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Length of the running off period
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			n <= 16'h0;
		end else begin
			n <= off_active_o ? n + 16'h1 : 16'h0;
		end
	end
	sequence s_pk;
		$rose(current_comparator_o) && gate_o && enable_i;
	endsequence
	a_off_low: assert property (off_active_o |-> !gate_o) else $error("on");
	a_en_low: assert property (!enable_i |=> !gate_o) else $error("idle");
	a_off_go: assert property ($rose(off_active_o) |-> $fell(gate_o)) else $error("go");
	a_fall_why: assert property ($fell(gate_o) && $past(enable_i) |-> off_active_o)
		else $error("fall");
	a_off_len: assert property ($fell(off_active_o) && enable_i |->
		n == (off_len_i > 1 ? off_len_i : 1)) else $error("len");
	a_back_on: assert property ($fell(off_active_o) && enable_i |-> gate_o) else $error("back");
	a_lag_direct: assert property (&route_i ##0 s_pk |->
		##1 !gate_o) else $error("lag");
	a_lag_relay: assert property (!route_i[0] ##0 s_pk |->
		##1 (gate_o || !enable_i) ##1 !gate_o) else $error("lag");
	a_lag_pins: assert property (route_i == 2'h1 ##0 s_pk |->
		##3 (gate_o || !enable_i) ##1 !gate_o) else $error("lag");
endmodule // pcot_monitor

/* File: dv/pcot_load.sv */
`timescale 1ns/1ps
module pcot_load (input wire logic clk_i, gate_i, output logic comp_o);
	// Coil current ramps while the switch is on
	logic [4:0] amps = 5'h00;
	// Saturates so a long on time cannot wrap the current back to zero
	always_ff @(posedge clk_i) amps <= gate_i ? amps + {4'h0, ~&amps} : amps - {4'h0, |amps};
	assign comp_o = amps[4];
endmodule // pcot_load

/* File: dv/test_pcot_top.sv */
`timescale 1ns/1ps
module test_pcot_top;
	logic clk_i = 1'h0, rst_i = 1'h1, enable_i = 1'h0, comp_raw_i, gate_o, comp_pin_o;
	logic current_comparator_o, ref_toggle_o, off_active_o;
	logic [15:0] off_len_i = 16'h0, ref_level_i = 16'h4000;
	pcot_pkg::pcot_route_type route_i = pcot_pkg::PCOT_ROUTE_RELAY;
	int err_total = 0, compares = 0, k;
	always #2.5 clk_i = ~clk_i;
	pcot_load u_load (.clk_i, .gate_i(gate_o), .comp_o(comp_raw_i));
	pcot_top u_dut (.*, .stop_pin_i(comp_pin_o));
	task automatic finish_test();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic off_test(input int r);
		@(posedge clk_i);
		enable_i <= 1'h0;
		route_i <= pcot_pkg::pcot_route_type'(r[1:0]);
		off_len_i <= 16'(r * r);
		repeat (30) @(posedge clk_i);
		enable_i <= 1'h1;
		while (gate_o !== 1'h1) @(negedge clk_i);
		while (gate_o !== 1'h0) @(negedge clk_i);
		for (k = 0; gate_o === 1'h0 && k < 300; k++) @(negedge clk_i);
		compares++;
		if (k != (r > 0 ? r * r : 1)) begin
			err_total++;
			$display("CHECK FAILED %0t %h %h", $time, k, r > 0 ? r * r : 1);
		end
		$display("route %0d done", r);
	endtask
	// Reference density 1/4: 64 high cycles in every 256
	task automatic ref_test();
		int highs;
		highs = 0;
		@(negedge clk_i);
		for (int j = 0; j < 256; j++) begin
			if (ref_toggle_o === 1'h1) highs++;
			@(negedge clk_i);
		end
		compares++;
		if (highs < 63 || highs > 65) begin
			err_total++;
			$display("CHECK FAILED %0t %h %h", $time, highs, 64);
		end
		$display("reference done");
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		for (int i = 0; i < 4; i++) off_test(i);
		ref_test();
		finish_test();
	end
	initial begin
		#20000;
		err_total++;
		finish_test();
	end
endmodule // test_pcot_top
bind pcot_top pcot_monitor u_mon (.*);
